// *** inc/mia_pkg.sv ***
// constants, level codes and source grouping of the interrupt arbiter
// assumes one system clock and request lines held high until cleared

package mia_pkg;

  localparam int NUM_SRC = 27;
  localparam int NUM_VEC = 10;

  // first source line of each vector; last entry closes the table
  localparam int VEC_FIRST [0:NUM_VEC] =
    '{0, 1, 2, 5, 9, 11, 14, 17, 20, 23, 27};

  // source lines that the standby logic watches
  localparam int SRC_BASE_TMR_A = 7;
  localparam int SRC_BASE_TMR_B = 8;
  localparam int SRC_PORT_ZERO  = 23;

  // external pins able to end hold: 0, 1, 2, 4, 5
  localparam logic [5:0] EXT_WAKE_MASK = 6'h37;

  // level codes
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_TOP  = 2'h3;

  // vectors whose upper choice is the highest level
  localparam int NUM_TOP_VEC = 2;

  localparam logic [16:0] VEC_BASE = 17'h00003;
  localparam logic [16:0] VEC_STEP = 17'h00008;

  typedef enum logic [1:0] {
    MIA_RUN,
    MIA_HALT,
    MIA_HOLD,
    MIA_XHOLD
  } mia_state_e;

endpackage

// *** src/mia_arbiter.sv ***
// three-level vectored interrupt arbiter with standby wake-up
// assumes requests are synchronous levels and the core pulses
// core_ack when it takes a vector and core_ret when it returns

`timescale 1ns/10ps
`default_nettype none

module mia_arbiter #(
  parameter int NUM_SRC = mia_pkg::NUM_SRC,
  parameter int NUM_VEC = mia_pkg::NUM_VEC
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [NUM_SRC-1:0] src_req,
  input  wire logic [NUM_VEC-1:0] vec_lvl_sel,
  input  wire logic               core_ack,
  input  wire logic               core_ret,
  input  wire logic               halt_cmd,
  input  wire logic               hold_cmd,
  input  wire logic               xhold_cmd,
  input  wire logic               rst_pin_n,
  input  wire logic [5:0]         ext_pin,
  input  wire logic [5:0]         ext_wake_lvl,
  output var  logic               irq_req,
  output var  logic [3:0]         irq_vec,
  output var  logic [16:0]        irq_addr,
  output var  logic [1:0]         irq_lvl,
  output var  logic [1:0]         svc_lvl,
  output var  logic               halted,
  output var  logic               periph_stop,
  output var  logic               base_tmr_run,
  output var  logic               wake
);

  if (NUM_SRC != mia_pkg::NUM_SRC || NUM_VEC != mia_pkg::NUM_VEC)
  begin : g_chk
    $error("source and vector counts are fixed by the grouping table");
  end

  // ***************************************************************
  // functions
  // ***************************************************************

  function automatic logic [NUM_VEC-1:0] vec_pend(
    input logic [NUM_SRC-1:0] r
  );
    logic [NUM_VEC-1:0] p;
    p = '0;
    for (int v = 0; v < NUM_VEC; v++)
    begin
      for (int s = mia_pkg::VEC_FIRST[v];
           s < mia_pkg::VEC_FIRST[v+1]; s++)
      begin
        p[v] = p[v] | r[s];
      end
    end
    return p;
  endfunction

  function automatic logic [1:0] lvl_of(
    input int   v,
    input logic sel
  );
    logic [1:0] l;
    l = mia_pkg::LVL_LOW;
    if (sel && v < mia_pkg::NUM_TOP_VEC)
    begin
      l = mia_pkg::LVL_TOP;
    end
    else if (sel)
    begin
      l = mia_pkg::LVL_HIGH;
    end
    return l;
  endfunction

  function automatic logic [1:0] top_lvl(
    input logic [2:0] stk
  );
    logic [1:0] l;
    l = mia_pkg::LVL_NONE;
    if (stk[2])
    begin
      l = mia_pkg::LVL_TOP;
    end
    else if (stk[1])
    begin
      l = mia_pkg::LVL_HIGH;
    end
    else if (stk[0])
    begin
      l = mia_pkg::LVL_LOW;
    end
    return l;
  endfunction

  function automatic logic [16:0] addr_of(
    input logic [3:0] v
  );
    return mia_pkg::VEC_BASE + 17'(v) * mia_pkg::VEC_STEP;
  endfunction

  // ***************************************************************
  // in-service levels
  // ***************************************************************

  logic [2:0] stk_q;
  logic [2:0] stk_d;
  logic [1:0] svc_q;
  logic [1:0] svc_d;
  logic       irq_req_q;
  logic [1:0] irq_lvl_q;

  always_comb
  begin
    stk_d = stk_q;
    if (core_ret)
    begin
      case (top_lvl(stk_q))
        mia_pkg::LVL_TOP:  stk_d[2] = 1'b0;
        mia_pkg::LVL_HIGH: stk_d[1] = 1'b0;
        mia_pkg::LVL_LOW:  stk_d[0] = 1'b0;
        default:           stk_d = stk_q;
      endcase
    end
    if (core_ack && irq_req_q && irq_lvl_q != mia_pkg::LVL_NONE)
    begin
      stk_d[irq_lvl_q - 2'h1] = 1'b1;
    end
    svc_d = top_lvl(stk_d);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stk_q <= 3'h0;
      svc_q <= mia_pkg::LVL_NONE;
    end
    else
    begin
      stk_q <= stk_d;
      svc_q <= svc_d;
    end
  end

  // ***************************************************************
  // arbitration
  // ***************************************************************

  logic [NUM_VEC-1:0] pend;
  logic               win_any;
  logic [3:0]         win_vec;
  logic [1:0]         win_lvl;
  logic               irq_req_d;
  logic [3:0]         irq_vec_q;
  logic [3:0]         irq_vec_d;
  logic [16:0]        irq_addr_q;
  logic [16:0]        irq_addr_d;
  logic [1:0]         irq_lvl_d;

  always_comb
  begin
    pend    = vec_pend(src_req);
    win_any = 1'b0;
    win_vec = 4'h0;
    win_lvl = mia_pkg::LVL_NONE;
    // descending walk, so ties land on the smaller address
    for (int v = NUM_VEC - 1; v >= 0; v--)
    begin
      if (pend[v] && lvl_of(v, vec_lvl_sel[v]) > svc_d
          && lvl_of(v, vec_lvl_sel[v]) >= win_lvl)
      begin
        win_any = 1'b1;
        win_vec = 4'(v);
        win_lvl = lvl_of(v, vec_lvl_sel[v]);
      end
    end
    irq_req_d  = win_any;
    irq_vec_d  = win_vec;
    irq_addr_d = addr_of(win_vec);
    irq_lvl_d  = win_lvl;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_req_q  <= 1'b0;
      irq_vec_q  <= 4'h0;
      irq_addr_q <= mia_pkg::VEC_BASE;
      irq_lvl_q  <= mia_pkg::LVL_NONE;
    end
    else
    begin
      irq_req_q  <= irq_req_d;
      irq_vec_q  <= irq_vec_d;
      irq_addr_q <= irq_addr_d;
      irq_lvl_q  <= irq_lvl_d;
    end
  end

  // ***************************************************************
  // standby
  // ***************************************************************

  mia_pkg::mia_state_e st_q;
  mia_pkg::mia_state_e st_d;
  logic                pin_wake;
  logic                wake_q;
  logic                wake_d;
  logic                halted_q;
  logic                halted_d;
  logic                pstop_q;
  logic                pstop_d;
  logic                btmr_q;
  logic                btmr_d;

  always_comb
  begin
    pin_wake = !rst_pin_n || src_req[mia_pkg::SRC_PORT_ZERO]
      || |(~(ext_pin ^ ext_wake_lvl) & mia_pkg::EXT_WAKE_MASK);
    st_d   = st_q;
    wake_d = 1'b0;
    case (st_q)
      mia_pkg::MIA_RUN:
      begin
        if (hold_cmd)
        begin
          st_d = mia_pkg::MIA_HOLD;
        end
        else if (xhold_cmd)
        begin
          st_d = mia_pkg::MIA_XHOLD;
        end
        else if (halt_cmd)
        begin
          st_d = mia_pkg::MIA_HALT;
        end
      end
      mia_pkg::MIA_HALT:
      begin
        wake_d = win_any;
      end
      mia_pkg::MIA_HOLD:
      begin
        wake_d = pin_wake;
      end
      mia_pkg::MIA_XHOLD:
      begin
        wake_d = pin_wake
          || src_req[mia_pkg::SRC_BASE_TMR_A]
          || src_req[mia_pkg::SRC_BASE_TMR_B];
      end
      default:
      begin
        st_d = mia_pkg::MIA_RUN;
      end
    endcase
    if (wake_d)
    begin
      st_d = mia_pkg::MIA_RUN;
    end
    halted_d = st_d != mia_pkg::MIA_RUN;
    pstop_d  = st_d == mia_pkg::MIA_HOLD || st_d == mia_pkg::MIA_XHOLD;
    btmr_d   = st_d != mia_pkg::MIA_HOLD;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q     <= mia_pkg::MIA_RUN;
      wake_q   <= 1'b0;
      halted_q <= 1'b0;
      pstop_q  <= 1'b0;
      btmr_q   <= 1'b1;
    end
    else
    begin
      st_q     <= st_d;
      wake_q   <= wake_d;
      halted_q <= halted_d;
      pstop_q  <= pstop_d;
      btmr_q   <= btmr_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************

  assign irq_req      = irq_req_q;
  assign irq_vec      = irq_vec_q;
  assign irq_addr     = irq_addr_q;
  assign irq_lvl      = irq_lvl_q;
  assign svc_lvl      = svc_q;
  assign halted       = halted_q;
  assign periph_stop  = pstop_q;
  assign base_tmr_run = btmr_q;
  assign wake         = wake_q;

  // ***************************************************************
  // checks
  // ***************************************************************

  a_grant_above_svc: assert property (
    @(posedge clk) disable iff (sys_rst)
    irq_req_q |-> irq_lvl_q > svc_q)
    else $error("grant not above level in service");

  a_ack_pushes: assert property (
    @(posedge clk) disable iff (sys_rst)
    core_ack && irq_req_q && !core_ret |=> svc_q == $past(irq_lvl_q))
    else $error("taken level not in service");

  a_vec_addr: assert property (
    @(posedge clk) disable iff (sys_rst)
    irq_req_q |-> irq_addr_q == 17'h3 + {irq_vec_q, 3'h0})
    else $error("vector address wrong");

  a_lvl_choice: assert property (
    @(posedge clk) disable iff (sys_rst)
    irq_req_q |-> irq_lvl_q == ((($past(vec_lvl_sel) & (10'h001 << irq_vec_q))
      == 10'h000) ? 2'h1 : (irq_vec_q < 4'h2 ? 2'h3 : 2'h2)))
    else $error("level does not match its selection");

  a_src_pending: assert property (
    @(posedge clk) disable iff (sys_rst)
    irq_req_q |-> ($past(pend) & (10'h001 << irq_vec_q)) != 10'h000)
    else $error("granted vector had no source");

  a_tie_smaller: assert property (
    @(posedge clk) disable iff (sys_rst)
    irq_req_q && irq_vec_q != 4'h0 && irq_lvl_q == 2'h1
      |-> ($past(pend) & ((10'h1 << irq_vec_q) - 10'h1)) == 10'h0
      || $past(svc_d) != 2'h0)
    else $error("smaller address of equal level skipped");

  a_halt_wake: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_q == mia_pkg::MIA_HALT && win_any |=> !halted ##0 wake)
    else $error("halt not ended by interrupt");

  a_hold_wake: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_q == mia_pkg::MIA_HOLD && !rst_pin_n |=> !periph_stop)
    else $error("hold not ended by reset pin");

  a_xhold_tmr: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_q == mia_pkg::MIA_XHOLD |-> base_tmr_run)
    else $error("base timer stopped in crystal hold");

  a_pend_kept: assert property (
    @(posedge clk) disable iff (sys_rst)
    !irq_req_q && pend[0] && vec_lvl_sel[0] && svc_d == 2'h0
      |=> irq_req_q && irq_vec_q == 4'h0)
    else $error("pending request not granted when free");

endmodule

`default_nettype wire

// *** tb/mia_core_model.sv ***
// core model: takes offered vectors and returns from service
// assumes irq_req is registered and core pulses are one cycle

`timescale 1ns/10ps
`default_nettype none

module mia_core_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       irq_req,
  input  wire logic       take_en,
  input  wire logic [3:0] ack_wait,
  input  wire logic       ret_cmd,
  output var  logic       core_ack,
  output var  logic       core_ret
);
  logic [3:0] cnt_q;

  // ack only while an offer stands, after ack_wait idle cycles
  always @(posedge clk)
  begin
    core_ret <= #1 ret_cmd & ~sys_rst;
    if (sys_rst || !take_en || !irq_req || core_ack)
    begin
      cnt_q <= #1 4'h0;
      core_ack <= #1 1'b0;
    end
    else if (cnt_q == ack_wait)
      core_ack <= #1 1'b1;
    else
      cnt_q <= #1 cnt_q + 4'h1;
  end
endmodule

`default_nettype wire

// *** tb/multilevel_interrupt_arbiter_bench.sv ***
// self-checking bench of the interrupt arbiter
// assumes mia_core_model stands in for the core

`timescale 1ns/10ps
`default_nettype none

module multilevel_interrupt_arbiter_bench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [26:0] src_req = '0;
  logic [9:0]  sel = '0;
  logic        take_en = 1'b0;
  logic        ret_cmd = 1'b0;
  logic [3:0]  ack_wait = 4'h0;
  logic        halt_cmd = 1'b0;
  logic        hold_cmd = 1'b0;
  logic        xhold_cmd = 1'b0;
  logic        rst_pin_n = 1'b1;
  logic [5:0]  ext_pin = 6'h00;
  logic [5:0]  wake_lvl = 6'h3F;
  logic        core_ack, core_ret, irq_req, halted;
  logic        periph_stop, base_tmr_run, wake;
  logic [3:0]  irq_vec;
  logic [16:0] irq_addr;
  logic [1:0]  irq_lvl, svc_lvl;
  int          n_mismatch = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  mia_arbiter dut (.clk(clk), .sys_rst(sys_rst), .src_req(src_req),
    .vec_lvl_sel(sel), .core_ack(core_ack), .core_ret(core_ret),
    .halt_cmd(halt_cmd), .hold_cmd(hold_cmd), .xhold_cmd(xhold_cmd),
    .rst_pin_n(rst_pin_n), .ext_pin(ext_pin), .ext_wake_lvl(wake_lvl),
    .irq_req(irq_req), .irq_vec(irq_vec), .irq_addr(irq_addr),
    .irq_lvl(irq_lvl), .svc_lvl(svc_lvl), .halted(halted),
    .periph_stop(periph_stop), .base_tmr_run(base_tmr_run), .wake(wake));

  mia_core_model core (.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req),
    .take_en(take_en), .ack_wait(ack_wait), .ret_cmd(ret_cmd),
    .core_ack(core_ack), .core_ret(core_ret));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [16:0] e,
                     input logic [16:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_wake;
    int i;
    i = 0;
    while (wake !== 1'b1 && i < 20)
    begin
      step(1);
      i++;
    end
    chk("wake", 17'h1, wake);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_map;
    for (int v = 0; v < 10; v++)
    begin
      src_req = '0;
      src_req[mia_pkg::VEC_FIRST[v+1] - 1] = 1'b1;
      step(2);
      chk("vec_last", 17'(v), irq_vec);
      src_req = '0;
      src_req[mia_pkg::VEC_FIRST[v]] = 1'b1;
      step(2);
      chk("vec", 17'(v), irq_vec);
      chk("addr", 17'h00003 + 17'(8 * v), irq_addr);
      chk("lvl", 17'h1, irq_lvl);
    end
    src_req = '0;
    step(2);
    $display("test map done");
  endtask

  task automatic t_prio;
    sel = 10'h009;
    src_req = 27'h0000025;
    step(2);
    chk("vec", 17'h0, irq_vec);
    chk("lvl", 17'h3, irq_lvl);
    src_req[0] = 1'b0;
    step(2);
    chk("vec", 17'h3, irq_vec);
    chk("lvl", 17'h2, irq_lvl);
    sel = 10'h000;
    src_req = 27'h0000A04;
    step(2);
    chk("vec", 17'h2, irq_vec);
    src_req = '0;
    $display("test prio done");
  endtask

  task automatic t_nest;
    ack_wait = 4'h3;
    sel = 10'h004;
    src_req = 27'h0000004;
    take_en = 1'b1;
    step(9);
    take_en = 1'b0;
    chk("svc", 17'h2, svc_lvl);
    chk("req", 17'h0, irq_req);
    src_req[0] = 1'b1;
    step(2);
    chk("req", 17'h0, irq_req);
    sel[0] = 1'b1;
    step(2);
    chk("req", 17'h1, irq_req);
    chk("lvl", 17'h3, irq_lvl);
    src_req[0] = 1'b0;
    ret_cmd = 1'b1;
    step(1);
    ret_cmd = 1'b0;
    step(3);
    chk("svc", 17'h0, svc_lvl);
    chk("vec", 17'h2, irq_vec);
    chk("req", 17'h1, irq_req);
    src_req = '0;
    sel = '0;
    $display("test nest done");
  endtask

  task automatic t_standby;
    for (int k = 0; k < 4; k++)
    begin
      if (k == 3)
        xhold_cmd = 1'b1;
      else
        hold_cmd = 1'b1;
      step(1);
      hold_cmd = 1'b0;
      xhold_cmd = 1'b0;
      step(1);
      chk("halted", 17'h1, halted);
      chk("pstop", 17'h1, periph_stop);
      chk("btmr", 17'(k == 3), base_tmr_run);
      case (k)
        0: rst_pin_n = 1'b0;
        1:
        begin
          wake_lvl = 6'h2F;
          ext_pin = 6'h18;
          step(2);
          chk("halted", 17'h1, halted);
          ext_pin[4] = 1'b0;
        end
        2: src_req[23] = 1'b1;
        default: src_req[7] = 1'b1;
      endcase
      wait_wake();
      chk("halted", 17'h0, halted);
      rst_pin_n = 1'b1;
      ext_pin = 6'h00;
      wake_lvl = 6'h3F;
      src_req = '0;
      step(2);
      chk("wake", 17'h0, wake);
    end
    $display("test standby done");
  endtask

  task automatic t_halt;
    halt_cmd = 1'b1;
    step(1);
    halt_cmd = 1'b0;
    chk("halted", 17'h1, halted);
    chk("pstop", 17'h0, periph_stop);
    src_req[14] = 1'b1;
    wait_wake();
    chk("req", 17'h1, irq_req);
    src_req = '0;
    $display("test halt done");
  endtask

  initial
  begin
    step(8);
    sys_rst = 1'b0;
    chk("addr", 17'h00003, irq_addr);
    step(1);
    t_map();
    t_prio();
    t_nest();
    t_standby();
    t_halt();
    complete_run();
  end

  initial
  begin
    #20000;
    n_mismatch++;
    complete_run();
  end
endmodule

`default_nettype wire
